// File: ncx_pkg.sv
/*
 * ncx_pkg: shared constants for the nibble core execute block.
 * Operand selector codes, cycle counts, flag positions, reset values and ALU operation codes.
 * Assumes 12-bit instruction words and 4-bit data memory nibbles.
 */
package ncx_pkg;

	// operand selector codes
	localparam logic [1:0] SEL_A  = 2'h0;
	localparam logic [1:0] SEL_B  = 2'h1;
	localparam logic [1:0] SEL_MX = 2'h2;
	localparam logic [1:0] SEL_MY = 2'h3;

	// execution lengths in core clocks
	localparam logic [2:0] CYC_SHORT = 3'h5;
	localparam logic [2:0] CYC_LONG  = 3'h7;

	// flag bit positions inside the flag nibble (I D Z C)
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_D = 2;
	localparam int FLG_I = 3;

	// reset values
	localparam logic [3:0]  NIB_RST  = 4'h0;
	localparam logic [7:0]  SP_RST   = 8'h00;
	localparam logic [11:0] IDX_RST  = 12'h000;

	// page of the direct memory operand (addresses 000H..00FH)
	localparam logic [3:0] DIRECT_PAGE = 4'h0;
	localparam logic [7:0] DIRECT_HI   = 8'h00;

	// decimal adjust constants
	localparam logic [4:0] BCD_TEN = 5'h0A;
	localparam logic [3:0] BCD_SIX = 4'h6;

	localparam logic [7:0] ONE8  = 8'h01;
	localparam logic [3:0] ONE4  = 4'h1;

	// alu operations
	typedef enum logic [3:0] {
		OP_ADD  = 4'h0,
		OP_ADC  = 4'h1,
		OP_SUB  = 4'h2,
		OP_SBC  = 4'h3,
		OP_AND  = 4'h4,
		OP_OR   = 4'h5,
		OP_XOR  = 4'h6,
		OP_CMP  = 4'h7,
		OP_TST  = 4'h8,
		OP_RLC  = 4'h9,
		OP_RRC  = 4'hA,
		OP_NOT  = 4'hB,
		OP_PASS = 4'hC
	} ncx_op_t;

endpackage

// File: ncx_alu.sv
/*
 * ncx_alu: 4-bit combinational arithmetic and logic unit.
 * Assumes the caller latches the result and flags; decimal adjust
 * applies only to add and subtract kinds when dec_i is high.
 */
`timescale 1ns/1ns
module ncx_alu
	import ncx_pkg::*;
(
	// operands
	input  wire logic [3:0] a_i,
	input  wire logic [3:0] b_i,
	input  wire logic       c_i,
	input  wire logic       dec_i,
	input  wire ncx_op_t    op_i,
	// results
	output logic      [3:0] res_o,
	output logic            z_o,
	output logic            c_o
);

	logic [4:0] sum;
	logic [4:0] dif;
	logic       cin;

	// arithmetic core with optional decimal adjust [RULE21]
	always_comb begin
		cin   = (op_i == OP_ADC || op_i == OP_SBC) ? c_i : 1'b0;
		sum   = {1'b0, a_i} + {1'b0, b_i} + {4'h0, cin};
		dif   = {1'b0, a_i} - {1'b0, b_i} - {4'h0, cin};
		res_o = a_i;
		c_o   = c_i;
		case (op_i)
			OP_ADD, OP_ADC: begin // [RULE6] [RULE23]
				res_o = sum[3:0];
				c_o   = sum[4];
				if (dec_i && sum >= BCD_TEN) begin
					res_o = sum[3:0] + BCD_SIX;
					c_o   = 1'b1;
				end
			end
			OP_SUB, OP_SBC, OP_CMP: begin // [RULE7] [RULE9] [RULE23]
				res_o = dif[3:0];
				c_o   = dif[4];
				if (dec_i && op_i != OP_CMP && dif[4])
					res_o = dif[3:0] - BCD_SIX;
			end
			OP_AND, OP_TST: res_o = a_i & b_i; // [RULE8] [RULE10]
			OP_OR:          res_o = a_i | b_i;
			OP_XOR:         res_o = a_i ^ b_i;
			OP_RLC: begin // [RULE11]
				res_o = {a_i[2:0], c_i};
				c_o   = a_i[3];
			end
			OP_RRC: begin // [RULE12]
				res_o = {c_i, a_i[3:1]};
				c_o   = a_i[0];
			end
			OP_NOT:  res_o = ~a_i; // [RULE17]
			OP_PASS: res_o = b_i;
			default: res_o = a_i;
		endcase
		z_o = (res_o == NIB_RST); // [RULE23]
	end

endmodule // ncx_alu

// File: ncx_core.sv
/*
 * ncx_core: decode and execute for stack, stack pointer, arithmetic,
 * logic, rotate, memory step and indexed add/subtract instructions.
 * Assumes a fetch unit offers one 12-bit word with instr_valid_i and
 * waits for instr_ready_o; data memory reads are combinational.
 */
// Function
// [RULE1] two-bit selector picks A, B, MX, MY
// [RULE2] pop index nibble from stack, SP plus one
// [RULE3] pop four flags from stack in five
// [RULE4] load one SP nibble, flags untouched
// [RULE5] copy SP nibble to register, flags untouched
// [RULE6] add immediate or register, optional carry
// [RULE7] subtract immediate or register, optional borrow
// [RULE8] AND OR XOR update zero only
// [RULE9] compare sets flags, stores nothing
// [RULE10] bit test ANDs, sets zero only
// [RULE11] rotate left through carry, seven clocks
// [RULE12] rotate right through carry, five clocks
// [RULE13] increment or decrement direct memory nibble
// [RULE14] direct operand reaches 000H to 00FH only
// [RULE15] indexed add with carry, index post-increment
// [RULE16] indexed subtract with carry, index post-increment
// [RULE17] complement register, zero flag only
// [RULE18] index is page over eight-bit low part
// [RULE19] stack pointer built from two nibbles
// [RULE20] flag register holds I D Z C
// [RULE21] decimal flag adjusts decimal add/subtract
// [RULE22] hold busy for listed clock count
// [RULE23] zero on zero result, carry on overflow
`timescale 1ns/1ns
module ncx_core
	import ncx_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// instruction handshake
	input  wire logic [11:0] instr_i,
	input  wire logic        instr_valid_i,
	output logic             instr_ready_o,
	output logic             illegal_o,
	// data memory
	output logic      [11:0] mem_addr_o,
	input  wire logic [3:0]  mem_rdata_i,
	output logic      [3:0]  mem_wdata_o,
	output logic             mem_we_o,
	// architectural state
	output logic      [3:0]  acc_a_o,
	output logic      [3:0]  reg_b_o,
	output logic      [11:0] first_index_reg_o,
	output logic      [11:0] second_index_reg_o,
	output logic      [7:0]  stack_ptr_o,
	output logic      [3:0]  flags_o
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} ncx_state_t;

	typedef enum logic [3:0] {
		K_NONE, K_POPY, K_POPF, K_LDSP, K_STSP, K_ALU, K_MEMS, K_IDX
	} ncx_kind_t;

	ncx_state_t state_r;
	logic [2:0] cnt_r;
	logic [3:0] a_r;
	logic [3:0] b_r;
	logic [11:0] ix_r;        // first_index_page over first_index_low_byte
	logic [11:0] iy_r;        // second_index_page over second_index_low_byte
	logic [3:0] sph_r;        // stack_ptr_high_nibble
	logic [3:0] spl_r;        // stack_ptr_low_nibble
	logic [3:0] flg_r;

	// decode outputs
	ncx_kind_t   kind;
	ncx_op_t     op;
	logic [1:0]  dsel;
	logic [1:0]  ssel;
	logic        use_imm;
	logic        wr_dest;
	logic        upd_c;
	logic        dec_ok;
	logic        sp_hi;
	logic        step_y;
	logic [2:0]  ncyc;
	logic [3:0]  opa;
	logic [3:0]  opb;
	logic [3:0]  alu_res;
	logic        alu_z;
	logic        alu_c;
	logic        fire;
	logic [11:0] ea;

	wire [3:0] imm4 = instr_i[3:0];
	wire [7:0] sp_w = {sph_r, spl_r}; // [RULE19]

	// selector decode, shared by destination and source [RULE1]
	function automatic logic [3:0] sel_val(input logic [1:0] s,
		input logic [3:0] a, input logic [3:0] b, input logic [3:0] m);
		case (s)
			SEL_A:   sel_val = a;
			SEL_B:   sel_val = b;
			default: sel_val = m;
		endcase
	endfunction

	function automatic logic [11:0] sel_addr(input logic [1:0] s,
		input logic [11:0] x, input logic [11:0] y);
		sel_addr = (s == SEL_MY) ? y : x;
	endfunction

	// low byte post-increment keeps the page nibble [RULE18]
	function automatic logic [11:0] idx_inc(input logic [11:0] v);
		idx_inc = {v[11:8], v[7:0] + ONE8};
	endfunction

	assign fire          = instr_valid_i && state_r == ST_IDLE;
	assign instr_ready_o = (state_r == ST_IDLE);

	// instruction decode
	always_comb begin
		kind    = K_NONE;
		op      = OP_PASS;
		dsel    = instr_i[3:2];
		ssel    = instr_i[1:0];
		use_imm = 1'b0;
		wr_dest = 1'b1;
		upd_c   = 1'b1;
		dec_ok  = 1'b0;
		sp_hi   = 1'b0;
		step_y  = 1'b0;
		ncyc    = CYC_LONG;
		casez (instr_i)
			12'b1111_1101_100?, 12'b1111_1101_1010: begin
				kind = (instr_i[1]) ? K_POPF : K_POPY; // [RULE2] [RULE3]
				ncyc = CYC_SHORT;
			end
			12'b1111_111?_0???: begin
				kind  = instr_i[2] ? K_STSP : K_LDSP; // [RULE4] [RULE5]
				sp_hi = ~instr_i[4]; // bit 4 picks the low nibble
				dsel  = instr_i[1:0];
				ncyc  = CYC_SHORT;
			end
			12'b1100_????_????, 12'b1101_????_????: begin
				kind    = K_ALU;
				dsel    = instr_i[5:4];
				use_imm = 1'b1;
				case (instr_i[9:6])
					4'h0: begin op = OP_ADD; dec_ok = 1'b1; end
					4'h1: begin op = OP_ADC; dec_ok = 1'b1; end
					4'h2: op = OP_AND;
					4'h3: op = OP_OR;
					4'h4: op = OP_XOR;
					4'h5: begin op = OP_SBC; dec_ok = 1'b1; end
					4'h6: op = OP_TST;
					4'h7: op = OP_CMP;
					default: kind = K_NONE;
				endcase
				if (instr_i[9:6] == 4'h4 && instr_i[3:0] == 4'hF) begin
					op = OP_NOT; // NOT r shares the XOR-immediate row
					use_imm = 1'b0;
				end
				wr_dest = !(op == OP_CMP || op == OP_TST);
				upd_c   = !(op == OP_AND || op == OP_OR || op == OP_XOR
					|| op == OP_TST || op == OP_NOT);
			end
			12'b1010_1???_????: begin
				kind = K_ALU;
				dsel = instr_i[3:2];
				case (instr_i[6:4])
					3'h0: begin op = OP_ADD; dec_ok = 1'b1; end
					3'h1: begin op = OP_ADC; dec_ok = 1'b1; end
					3'h2: begin op = OP_SUB; dec_ok = 1'b1; end
					3'h3: begin op = OP_SBC; dec_ok = 1'b1; end
					3'h4: op = OP_AND;
					3'h5: op = OP_OR;
					3'h6: op = OP_XOR;
					default: op = OP_RLC;
				endcase
				upd_c = !(op == OP_AND || op == OP_OR || op == OP_XOR);
			end
			12'b1111_0000_????, 12'b1111_0001_????: begin
				kind    = K_ALU;
				dsel    = instr_i[3:2];
				op      = instr_i[4] ? OP_TST : OP_CMP;
				wr_dest = 1'b0;
				upd_c   = ~instr_i[4];
			end
			12'b1110_1000_11??: begin
				kind = K_ALU;
				op   = OP_RRC;
				dsel = instr_i[1:0];
				ncyc = CYC_SHORT;
			end
			12'b1111_0110_????, 12'b1111_0111_????: begin
				kind = K_MEMS; // [RULE13]
				op   = instr_i[4] ? OP_SUB : OP_ADD;
			end
			12'b1111_0010_1???, 12'b1111_0011_1???: begin
				kind   = K_IDX; // [RULE15] [RULE16]
				op     = instr_i[4] ? OP_SBC : OP_ADC;
				step_y = instr_i[2];
				dsel   = instr_i[2] ? SEL_MY : SEL_MX;
				ssel   = instr_i[1:0];
				dec_ok = 1'b1;
			end
			default: kind = K_NONE;
		endcase
	end

	// effective memory address for the operation
	always_comb begin
		case (kind)
			K_POPY, K_POPF: ea = {DIRECT_PAGE, sp_w};
			K_MEMS:         ea = {DIRECT_HI, imm4}; // [RULE14]
			default:        ea = sel_addr(dsel, ix_r, iy_r);
		endcase
	end

	// operand fetch through the selector decoder [RULE1]
	always_comb begin
		opa = sel_val(dsel, a_r, b_r, mem_rdata_i);
		opb = use_imm ? imm4
			: sel_val(ssel, a_r, b_r, mem_rdata_i);
		if (kind == K_MEMS) begin
			opa = mem_rdata_i;
			opb = ONE4;
		end
		if (kind == K_IDX)
			opb = sel_val(ssel, a_r, b_r, NIB_RST);
	end

	ncx_alu u_alu (
		.a_i   (opa),
		.b_i   (opb),
		.c_i   (flg_r[FLG_C]),
		.dec_i (flg_r[FLG_D] && dec_ok),
		.op_i  (op),
		.res_o (alu_res),
		.z_o   (alu_z),
		.c_o   (alu_c)
	);

	// busy counter: ready again after the listed clocks [RULE22]
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_r <= ST_IDLE;
			cnt_r   <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE: if (fire && ncyc > 3'h1) begin
					state_r <= ST_BUSY;
					cnt_r   <= ncyc - 3'h2;
				end
				ST_BUSY: if (cnt_r == 3'h0) state_r <= ST_IDLE;
					else cnt_r <= cnt_r - 3'h1;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// memory write path, issued in the decode cycle
	always_comb begin
		mem_addr_o  = ea;
		mem_we_o    = 1'b0;
		mem_wdata_o = alu_res;
		if (fire) begin
			case (kind)
				K_ALU: mem_we_o = wr_dest && dsel[1];
				K_STSP: begin
					mem_we_o    = dsel[1]; // [RULE5]
					mem_wdata_o = sp_hi ? sph_r : spl_r;
				end
				K_MEMS, K_IDX: mem_we_o = 1'b1;
				default: mem_we_o = 1'b0;
			endcase
		end
	end

	// accumulator and B register updates
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			a_r <= NIB_RST;
			b_r <= NIB_RST;
		end else if (fire) begin
			if (kind == K_ALU && wr_dest && dsel == SEL_A) a_r <= alu_res;
			if (kind == K_ALU && wr_dest && dsel == SEL_B) b_r <= alu_res;
			if (kind == K_STSP && dsel == SEL_A)
				a_r <= sp_hi ? sph_r : spl_r; // [RULE5]
			if (kind == K_STSP && dsel == SEL_B)
				b_r <= sp_hi ? sph_r : spl_r;
		end
	end

	// index registers: pops and post-increment [RULE18]
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ix_r <= IDX_RST;
			iy_r <= IDX_RST;
		end else if (fire) begin
			if (kind == K_POPY && instr_i[0])
				iy_r[3:0] <= mem_rdata_i; // [RULE2]
			if (kind == K_POPY && !instr_i[0])
				iy_r[7:4] <= mem_rdata_i;
			if (kind == K_IDX && !step_y) ix_r <= idx_inc(ix_r); // [RULE15]
			if (kind == K_IDX && step_y)  iy_r <= idx_inc(iy_r); // [RULE16]
		end
	end

	// stack pointer nibbles [RULE19]
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sph_r <= SP_RST[7:4];
			spl_r <= SP_RST[3:0];
		end else if (fire) begin
			if (kind == K_POPY || kind == K_POPF)
				{sph_r, spl_r} <= sp_w + ONE8; // [RULE2] [RULE3]
			if (kind == K_LDSP && sp_hi)
				sph_r <= sel_val(dsel, a_r, b_r, mem_rdata_i); // [RULE4]
			if (kind == K_LDSP && !sp_hi)
				spl_r <= sel_val(dsel, a_r, b_r, mem_rdata_i);
		end
	end

	// flag register I D Z C [RULE20]
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			flg_r <= NIB_RST;
		end else if (fire) begin
			case (kind)
				K_POPF: flg_r <= mem_rdata_i; // [RULE3]
				K_ALU, K_MEMS, K_IDX: begin
					flg_r[FLG_Z] <= alu_z; // [RULE23]
					if (upd_c) flg_r[FLG_C] <= alu_c;
				end
				default: flg_r <= flg_r; // [RULE4] [RULE5]
			endcase
		end
	end

	// state outputs come straight from the registers
	assign acc_a_o            = a_r;
	assign reg_b_o            = b_r;
	assign first_index_reg_o  = ix_r;
	assign second_index_reg_o = iy_r;
	assign stack_ptr_o        = sp_w;
	assign flags_o            = flg_r;
	assign illegal_o          = fire && kind == K_NONE;

	// checks

	a_busy_long: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && ncyc == CYC_LONG |=> !instr_ready_o [*6] ##1 instr_ready_o)
		else $error("long op busy length wrong"); // [RULE22]

	a_busy_short: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && ncyc == CYC_SHORT |=> !instr_ready_o [*4] ##1 instr_ready_o)
		else $error("short op busy length wrong"); // [RULE22]

	a_pop_sp_inc: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && kind == K_POPF |=> stack_ptr_o == $past(sp_w) + ONE8)
		else $error("pop did not bump stack pointer"); // [RULE3]

	a_ldsp_flags: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && (kind == K_LDSP || kind == K_STSP) |=> $stable(flags_o))
		else $error("sp move changed flags"); // [RULE4]

	a_zero_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && kind == K_ALU |=> flags_o[FLG_Z] == (($past(alu_res)) == 4'h0))
		else $error("zero flag mismatch"); // [RULE23]

	a_logic_carry: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && kind == K_ALU && (op == OP_AND || op == OP_OR)
		|=> flags_o[FLG_C] == $past(flg_r[FLG_C]))
		else $error("logic op touched carry"); // [RULE8]

	a_cmp_nowrite: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && op == OP_CMP |=> acc_a_o == $past(a_r) && reg_b_o == $past(b_r))
		else $error("compare stored a result"); // [RULE9]

	a_idx_page: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && kind == K_IDX && !step_y
		|=> first_index_reg_o[11:8] == $past(ix_r[11:8])
		&& first_index_reg_o[7:0] == $past(ix_r[7:0]) + ONE8)
		else $error("index post-increment wrong"); // [RULE15]

	a_direct_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fire && kind == K_MEMS |-> mem_addr_o[11:4] == DIRECT_HI && mem_we_o)
		else $error("direct operand out of range"); // [RULE14]

endmodule // ncx_core

// File: nibble_cpu_stack_alu_ops_bench.sv
/*
 * nibble_cpu_stack_alu_ops_bench: self-checking bench for ncx_core.
 * Assumes a 10 MHz core clock, a combinational data memory modelled
 * here, and inputs driven at the falling edge of the clock.
 */
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
	miscompares++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module nibble_cpu_stack_alu_ops_bench;
	import ncx_pkg::*;

	// one row: word, clocks, then expected A B F SP X Y after it
	typedef struct packed {
		logic [11:0] w;
		logic [2:0]  n;
		logic [3:0]  a;
		logic [3:0]  b;
		logic [3:0]  f;
		logic [7:0]  sp;
		logic [11:0] x;
		logic [11:0] y;
	} ncx_row_t;

	// dut connections
	logic        clk;
	logic        resetn;
	logic [11:0] instr;
	logic        instr_valid;
	logic        instr_ready;
	logic        illegal;
	logic [11:0] mem_addr;
	logic [3:0]  mem_rdata;
	logic [3:0]  mem_wdata;
	logic        mem_we;
	logic [3:0]  acc_a;
	logic [3:0]  reg_b;
	logic [11:0] idx_first;
	logic [11:0] idx_second;
	logic [7:0]  stack_ptr;
	logic [3:0]  flags;
	logic [3:0]  mem [0:4095];
	int          miscompares = 0;
	int          checked = 0;

	// rows run in order, each building on the state the last one left
	ncx_row_t rows [41] = '{
		'{12'hC09,3'h7,4'h9,4'h0,4'h0,8'h00,12'h000,12'h000},
		'{12'hC18,3'h7,4'h9,4'h8,4'h0,8'h00,12'h000,12'h000},
		'{12'hA81,3'h7,4'h1,4'h8,4'h1,8'h00,12'h000,12'h000},
		'{12'hC42,3'h7,4'h4,4'h8,4'h0,8'h00,12'h000,12'h000},
		'{12'hAA1,3'h7,4'hC,4'h8,4'h1,8'h00,12'h000,12'h000},
		'{12'hD42,3'h7,4'h9,4'h8,4'h0,8'h00,12'h000,12'h000},
		'{12'hAB4,3'h7,4'h9,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hC83,3'h7,4'h1,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hAC1,3'h7,4'h1,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hD01,3'h7,4'h0,4'hF,4'h3,8'h00,12'h000,12'h000},
		'{12'hCC6,3'h7,4'h6,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hAD1,3'h7,4'hF,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hAE1,3'h7,4'h0,4'hF,4'h3,8'h00,12'h000,12'h000},
		'{12'hDDF,3'h7,4'h0,4'hF,4'h2,8'h00,12'h000,12'h000},
		'{12'hF01,3'h7,4'h0,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hD90,3'h7,4'h0,4'hF,4'h3,8'h00,12'h000,12'h000},
		'{12'hF15,3'h7,4'h0,4'hF,4'h1,8'h00,12'h000,12'h000},
		'{12'hD1F,3'h7,4'h0,4'h0,4'h3,8'h00,12'h000,12'h000},
		'{12'hAF5,3'h7,4'h0,4'h1,4'h0,8'h00,12'h000,12'h000},
		'{12'hE8D,3'h5,4'h0,4'h0,4'h3,8'h00,12'h000,12'h000},
		'{12'hE8C,3'h5,4'h8,4'h0,4'h0,8'h00,12'h000,12'h000},
		'{12'hF65,3'h7,4'h8,4'h0,4'h0,8'h00,12'h000,12'h000},
		'{12'hF65,3'h7,4'h8,4'h0,4'h3,8'h00,12'h000,12'h000},
		'{12'hF76,3'h7,4'h8,4'h0,4'h1,8'h00,12'h000,12'h000},
		'{12'hFF0,3'h5,4'h8,4'h0,4'h1,8'h08,12'h000,12'h000},
		'{12'hFE2,3'h5,4'h8,4'h0,4'h1,8'h78,12'h000,12'h000},
		'{12'hFE5,3'h5,4'h8,4'h7,4'h1,8'h78,12'h000,12'h000},
		'{12'hFF4,3'h5,4'h8,4'h7,4'h1,8'h78,12'h000,12'h000},
		'{12'hFD8,3'h5,4'h8,4'h7,4'h1,8'h79,12'h000,12'h0C0},
		'{12'hFD9,3'h5,4'h8,4'h7,4'h1,8'h7A,12'h000,12'h0C3},
		'{12'hFDA,3'h5,4'h8,4'h7,4'hE,8'h7B,12'h000,12'h0C3},
		'{12'hC05,3'h7,4'h3,4'h7,4'hD,8'h7B,12'h000,12'h0C3},
		'{12'hAA1,3'h7,4'h6,4'h7,4'hD,8'h7B,12'h000,12'h0C3},
		'{12'hF2D,3'h7,4'h6,4'h7,4'hD,8'h7B,12'h000,12'h0C4},
		'{12'hFDA,3'h5,4'h6,4'h7,4'h1,8'h7C,12'h000,12'h0C4},
		'{12'hF38,3'h7,4'h6,4'h7,4'h2,8'h7C,12'h001,12'h0C4},
		'{12'hF29,3'h7,4'h6,4'h7,4'h1,8'h7C,12'h002,12'h0C4},
		'{12'hF3C,3'h7,4'h6,4'h7,4'h1,8'h7C,12'h002,12'h0C5},
		'{12'hFD8,3'h5,4'h6,4'h7,4'h1,8'h7D,12'h002,12'h0F5},
		'{12'hFD9,3'h5,4'h6,4'h7,4'h1,8'h7E,12'h002,12'h0FF},
		'{12'hF2C,3'h7,4'h6,4'h7,4'h0,8'h7E,12'h002,12'h000}
	};

	ncx_core u_dut (
		.clk_i              (clk),
		.resetn_i           (resetn),
		.instr_i            (instr),
		.instr_valid_i      (instr_valid),
		.instr_ready_o      (instr_ready),
		.illegal_o          (illegal),
		.mem_addr_o         (mem_addr),
		.mem_rdata_i        (mem_rdata),
		.mem_wdata_o        (mem_wdata),
		.mem_we_o           (mem_we),
		.acc_a_o            (acc_a),
		.reg_b_o            (reg_b),
		.first_index_reg_o  (idx_first),
		.second_index_reg_o (idx_second),
		.stack_ptr_o        (stack_ptr),
		.flags_o            (flags)
	);

	// clock and data memory; reads are combinational like the real array
	always #50 clk = ~clk;
	assign mem_rdata = mem[mem_addr];
	always @(posedge clk) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	task end_sim;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// offer a word, then keep offering an add of one to A while busy;
	// a correct core refuses it, so the expected state stays exact
	task exec(input logic [11:0] w, input logic [2:0] n, input logic ill);
		int cnt;
		instr = w;
		instr_valid = 1'b1;
		#1 `CHK(illegal, ill)
		@(negedge clk);
		cnt = 0;
		while (instr_ready !== 1'b1 && cnt < 20) begin
			instr = 12'hC01;
			cnt++;
			@(negedge clk);
		end
		if (cnt >= 20) begin
			miscompares++;
			end_sim();
		end
		`CHK(cnt, n - 1)
	endtask

	task check_zero;
		`CHK(acc_a, 4'h0)
		`CHK(reg_b, 4'h0)
		`CHK(idx_first, 12'h000)
		`CHK(idx_second, 12'h000)
		`CHK(stack_ptr, 8'h00)
		`CHK(flags, 4'h0)
		`CHK(instr_ready, 1'b1)
		`CHK(mem_we, 1'b0)
	endtask

	// a hang anywhere is cut short here
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		instr = 12'h000;
		instr_valid = 1'b0;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 4'h0;
		end
		mem[12'h000] = 4'h7;
		mem[12'h001] = 4'hA;
		mem[12'h005] = 4'hE;
		mem[12'h078] = 4'hC;
		mem[12'h079] = 4'h3;
		mem[12'h07A] = 4'hE;
		mem[12'h07B] = 4'h1;
		mem[12'h07C] = 4'hF;
		mem[12'h07D] = 4'hF;
		mem[12'h0C3] = 4'h4;
		mem[12'h0C4] = 4'h2;
		mem[12'h0FF] = 4'h5;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		check_zero();
		$display("reset test done");

		// ordinary cases, issued back to back at the earliest edge
		for (int i = 0; i < 41; i++) begin
			exec(rows[i].w, rows[i].n, 1'b0);
			`CHK(acc_a, rows[i].a)
			`CHK(reg_b, rows[i].b)
			`CHK(flags, rows[i].f)
			`CHK(stack_ptr, rows[i].sp)
			`CHK(idx_first, rows[i].x)
			`CHK(idx_second, rows[i].y)
		end
		`CHK(mem[12'h005], 4'h0)
		`CHK(mem[12'h006], 4'hF)
		`CHK(mem[12'h000], 4'h0)
		`CHK(mem[12'h001], 4'h1)
		`CHK(mem[12'h0C3], 4'h2)
		`CHK(mem[12'h0C4], 4'hB)
		`CHK(mem[12'h0FF], 4'hC)
		$display("table test done");

		// a word outside this block is flagged and leaves state alone
		exec(12'h000, 3'h7, 1'b1);
		`CHK(acc_a, 4'h6)
		`CHK(flags, 4'h0)
		$display("illegal word test done");

		// reset while an add is still busy
		instr = 12'hC05;
		@(posedge clk);
		@(negedge clk);
		instr_valid = 1'b0;
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		check_zero();
		$display("mid-run reset test done");
		end_sim();
	end

endmodule // nibble_cpu_stack_alu_ops_bench
